// *** ivpm_assertions.sv ***
// Checker for the vector and priority map, bound to its top module.
// Assumes prio_regs and line_enable stay put while a vector is offered.
`timescale 1ns/100ps

module ivpm_chk
    import ivpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Observed ports
    input wire ivpm_src_s src,
    input wire logic [NUM_PRIO_REGS*32-1:0] prio_regs,
    input wire logic [NUM_LINES-1:0] line_enable,
    input wire logic core_ack,
    input wire logic core_req,
    input wire ivpm_vec_s vec_out,
    input wire logic [NUM_LINES-1:0] pending,
    input wire logic [NUM_LINES-1:0] line_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Line of the offered vector is the vector minus 16
    wire logic [5:0] line_no = vec_out.vector - 6'h10;
    // Field of the offered line: register line/4, bit 8*(line%4)+6
    wire logic [1:0] lvl_exp = prio_regs[{line_no[4:0], 3'b110} +: 2];
    wire logic periph = core_req && (vec_out.vector >= 6'h10);

    // ----------------------------------------------------------------
    // Handshake steps
    // ----------------------------------------------------------------
    sequence s_wait;
        core_req && !core_ack;
    endsequence
    sequence s_served;
        core_req && core_ack;
    endsequence

    property p_hold;
        s_wait |=> core_req && $stable(vec_out);
    endproperty
    a_hold: assert property (p_hold) else $error("vector dropped early");
    property p_ack;
        s_served |=> !core_req;
    endproperty
    a_ack: assert property (p_ack) else $error("request after ack");

    // ----------------------------------------------------------------
    // Vector table
    // ----------------------------------------------------------------
    property p_addr;
        vec_out.valid |-> vec_out.addr == {24'h0, vec_out.vector, 2'b00};
    endproperty
    a_addr: assert property (p_addr) else $error("bad table address");
    property p_core_vec;
        core_req && (vec_out.vector < 6'h10) |->
            vec_out.vector inside {6'h02, 6'h03, 6'h0B, 6'h0E, 6'h0F};
    endproperty
    a_core_vec: assert property (p_core_vec) else $error("unused vector");
    property p_line;
        periph |-> pending[line_no[4:0]];
    endproperty
    a_line: assert property (p_line) else $error("line not pending");
    property p_level;
        periph |-> vec_out.level == lvl_exp;
    endproperty
    a_level: assert property (p_level) else $error("wrong level");

    // ----------------------------------------------------------------
    // Line routing
    // ----------------------------------------------------------------
    property p_spare;
        (line_req & 32'hC404_6A1F) == 32'h0;
    endproperty
    a_spare: assert property (p_spare) else $error("spare line set");
    property p_conv;
        line_req[15] == src.converter && line_req[16] == src.comparator0
            && line_req[21] == src.comparator1;
    endproperty
    a_conv: assert property (p_conv) else $error("analog routing");
    property p_merge;
        line_req[8] == |src.two_wire && line_req[10] == |src.serial_periph
            && line_req[17] == |src.pwm_timer0
            && line_req[19] == |src.pwm_timer2
            && line_req[29] == |src.pulse_width;
    endproperty
    a_merge: assert property (p_merge) else $error("merge routing");
    property p_pend;
        (pending & ~$past(pending) & ~($past(line_req) & $past(line_enable)))
            == 32'h0;
    endproperty
    a_pend: assert property (p_pend) else $error("pend without cause");
endmodule : ivpm_chk

bind ivpm_top ivpm_chk i_ivpm_chk (.clk, .rst, .src, .prio_regs,
    .line_enable, .core_ack, .core_req, .vec_out, .pending, .line_req);

// *** ivpm_core_model.sv ***
// Core-side model: takes each offered vector and acknowledges it.
// Assumes a one-cycle ack; delay sets how many cycles the core stalls.
`timescale 1ns/100ps

module ivpm_core_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Handshake
    input wire logic core_req,
    input wire logic [3:0] delay,
    output logic core_ack
);
    int wait_cnt = 0;

    initial core_ack = 1'b0;

    // One pulse per vector; a stalled core keeps the vector on offer
    always @(posedge clk)
    begin
        #1;
        if (rst || core_ack || !core_req)
        begin
            core_ack = 1'b0;
            wait_cnt = 0;
        end
        else if (wait_cnt >= delay)
            core_ack = 1'b1;
        else
            wait_cnt++;
    end
endmodule : ivpm_core_model

// *** ivpm_line_map.sv ***
// Merges and routes peripheral source requests onto the 32 request lines.
// Assumes all sources are on the core clock; lines are combinational.
`timescale 1ns/100ps

module ivpm_line_map
    import ivpm_pkg::*;
(
    // Sources
    input wire ivpm_src_s src,
    // Request lines
    output logic [NUM_LINES-1:0] lines
);

    // ------------------------------------------------------------
    // Line routing
    // ------------------------------------------------------------
    // Unlisted bits stay zero so spare lines never request
    always_comb
    begin
        lines = '0;
        lines[LINE_FLASH_CMD] = src.flash_cmd;
        lines[LINE_LOW_VOLT] = src.low_volt;
        lines[LINE_EXT_PIN] = src.ext_pin;
        lines[LINE_TWO_WIRE] = |src.two_wire;
        lines[LINE_SERIAL_PERIPH] = |src.serial_periph;
        lines[LINE_ASYNC_SERIAL] = src.async_serial;
        lines[LINE_CONVERTER] = src.converter;
        lines[LINE_COMPARATOR0] = src.comparator0;
        lines[LINE_PWM_TIMER0] = |src.pwm_timer0;
        lines[LINE_PWM_TIMER2] = |src.pwm_timer2;
        lines[LINE_RTC_OVF] = src.rtc_ovf;
        lines[LINE_COMPARATOR1] = src.comparator1;
        lines[LINE_PIT0] = src.pit0;
        lines[LINE_PIT1] = src.pit1;
        lines[LINE_KEYPAD0] = src.keypad0;
        lines[LINE_KEYPAD1] = src.keypad1;
        lines[LINE_CLOCK_LOSS] = src.clock_loss;
        lines[LINE_WATCHDOG] = src.watchdog;
        lines[LINE_PULSE_WIDTH] = |src.pulse_width;
    end

endmodule : ivpm_line_map

// *** ivpm_pkg.sv ***
// Shared constants and carriers for the interrupt vector and priority map.
// Assumes one core clock and a synchronous active-high reset.
package ivpm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_LINES = 32;
    localparam int unsigned LEVEL_W = 2;
    localparam int unsigned LINE_W = 5;
    localparam int unsigned VEC_W = 6;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned PRIO_REG_W = 3;
    localparam int unsigned FIELD_POS_W = 5;
    localparam int unsigned NUM_PRIO_REGS = 8;
    localparam int unsigned LINES_PER_REG = 4;

    // ------------------------------------------------------------
    // Vector numbers and table layout
    // ------------------------------------------------------------
    localparam logic [VEC_W-1:0] VEC_STACK = 6'h00;
    localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
    localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
    localparam logic [VEC_W-1:0] VEC_HARD_FAULT = 6'h03;
    localparam logic [VEC_W-1:0] VEC_SUPERVISOR_CALL = 6'h0B;
    localparam logic [VEC_W-1:0] VEC_PENDABLE_SERVICE = 6'h0E;
    localparam logic [VEC_W-1:0] VEC_SYSTEM_TICK = 6'h0F;
    localparam logic [VEC_W-1:0] VEC_LINE_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] TABLE_BASE = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] PERIPH_TABLE_BASE = 32'h0000_0040;
    localparam logic [ADDR_W-1:0] SYSTEM_TICK_ADDR = 32'h0000_003C;
    localparam int unsigned ENTRY_SHIFT = 2;
    localparam int unsigned FIELD_STRIDE = 8;
    localparam int unsigned FIELD_OFFSET = 6;

    // ------------------------------------------------------------
    // Peripheral line assignment
    // ------------------------------------------------------------
    localparam int unsigned LINE_FLASH_CMD = 5;
    localparam int unsigned LINE_LOW_VOLT = 6;
    localparam int unsigned LINE_EXT_PIN = 7;
    localparam int unsigned LINE_TWO_WIRE = 8;
    localparam int unsigned LINE_SERIAL_PERIPH = 10;
    localparam int unsigned LINE_ASYNC_SERIAL = 12;
    localparam int unsigned LINE_CONVERTER = 15;
    localparam int unsigned LINE_COMPARATOR0 = 16;
    localparam int unsigned LINE_PWM_TIMER0 = 17;
    localparam int unsigned LINE_PWM_TIMER2 = 19;
    localparam int unsigned LINE_RTC_OVF = 20;
    localparam int unsigned LINE_COMPARATOR1 = 21;
    localparam int unsigned LINE_PIT0 = 22;
    localparam int unsigned LINE_PIT1 = 23;
    localparam int unsigned LINE_KEYPAD0 = 24;
    localparam int unsigned LINE_KEYPAD1 = 25;
    localparam int unsigned LINE_CLOCK_LOSS = 27;
    localparam int unsigned LINE_WATCHDOG = 28;
    localparam int unsigned LINE_PULSE_WIDTH = 29;

    // Reset values
    localparam logic [NUM_LINES-1:0] PEND_RESET = 32'h0000_0000;
    localparam logic [NUM_LINES*LEVEL_W-1:0] PRIO_RESET = 64'h0;

    // Vector fetch sequencer states, Gray along idle-take-fetch
    typedef enum logic [1:0]
    {
        IVPM_IDLE = 2'b00,
        IVPM_TAKE = 2'b01,
        IVPM_FETCH = 2'b11
    } ivpm_state_e;

    // Grouped peripheral source requests
    typedef struct packed
    {
        logic flash_cmd;
        logic low_volt;
        logic ext_pin;
        logic [1:0] two_wire;
        logic [1:0] serial_periph;
        logic async_serial;
        logic converter;
        logic comparator0;
        logic [7:0] pwm_timer0;
        logic [7:0] pwm_timer2;
        logic rtc_ovf;
        logic comparator1;
        logic pit0;
        logic pit1;
        logic keypad0;
        logic keypad1;
        logic clock_loss;
        logic watchdog;
        logic [1:0] pulse_width;
    } ivpm_src_s;

    // What the core sees of the chosen exception
    typedef struct packed
    {
        logic valid;
        logic [VEC_W-1:0] vector;
        logic [ADDR_W-1:0] addr;
        logic [LEVEL_W-1:0] level;
    } ivpm_vec_s;

endpackage : ivpm_pkg

// *** ivpm_top.sv ***
// Interrupt vector and priority map: routes sources to lines, resolves
// priority and hands the core one vector number and table address.
// Assumes the core acknowledges each taken vector with a one-cycle pulse.
`timescale 1ns/100ps

// Function
// - Four levels, two-bit field per line
// - Non-maskable from low pin when selected
// - Vector number is the value stacked
// - Line equals vector minus 16, base 0x40
// - Priority register is line divided by four
// - Core vectors 0,1,2,3,11,14 fixed
// - System tick vector 15 at 0x3C
// - Thirty-two request lines, numbered 0 to 31
// - Multi-source modules merge onto one line
// - Converter drives line 15, vector 31
// - Comparators drive lines 16 and 21
// - Field starts at 8*(line mod 4)+6
module ivpm_top
    import ivpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Peripheral sources and external pin
    input wire ivpm_src_s src,
    input wire logic nmi_pin_n,
    input wire logic nmi_func_sel,
    // Priority configuration, eight registers of four fields
    input wire logic [NUM_PRIO_REGS*32-1:0] prio_regs,
    input wire logic [NUM_LINES-1:0] line_enable,
    // Core system exception requests
    input wire logic hard_fault_req,
    input wire logic supervisor_call_req,
    input wire logic pendable_service_req,
    input wire logic system_tick_req,
    // Core handshake
    input wire logic core_ack,
    output logic core_req,
    output ivpm_vec_s vec_out,
    output logic [NUM_LINES-1:0] pending,
    output logic [NUM_LINES-1:0] line_req
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Register index for a line
    function automatic logic [PRIO_REG_W-1:0] prio_reg_of(
        input logic [LINE_W-1:0] line);
        prio_reg_of = line[LINE_W-1:2];
    endfunction : prio_reg_of

    // Bit position of a line's field within its register
    function automatic logic [FIELD_POS_W-1:0] field_pos_of(
        input logic [LINE_W-1:0] line);
        logic [FIELD_POS_W-1:0] m;
        m = FIELD_POS_W'(line % LINES_PER_REG);
        field_pos_of = FIELD_POS_W'(m * FIELD_STRIDE + FIELD_OFFSET);
    endfunction : field_pos_of

    // Table address of a vector, one word per entry
    function automatic logic [ADDR_W-1:0] vec_addr_of(
        input logic [VEC_W-1:0] vec);
        vec_addr_of = TABLE_BASE + (ADDR_W'(vec) << ENTRY_SHIFT);
    endfunction : vec_addr_of

    // ------------------------------------------------------------
    // Source routing
    // ------------------------------------------------------------
    ivpm_line_map u_line_map
    (
        .src(src),
        .lines(line_req)
    );

    // ------------------------------------------------------------
    // Pin synchroniser for the non-maskable pin
    // ------------------------------------------------------------
    logic nmi_meta_reg;
    logic nmi_sync_reg;
    logic nmi_prev_reg;
    logic nmi_pend_reg;

    // Two stages; pin idles high so reset to the inactive level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nmi_meta_reg <= 1'b1;
            nmi_sync_reg <= 1'b1;
            nmi_prev_reg <= 1'b1;
        end
        else
        begin
            nmi_meta_reg <= nmi_pin_n;
            nmi_sync_reg <= nmi_meta_reg;
            nmi_prev_reg <= nmi_sync_reg;
        end
    end

    // The detector reads the second stage and its delayed copy, never the first; the first may still be
    // settling from a metastable sample
    // Falling edge only counts while the pin carries that function
    wire nmi_edge = nmi_prev_reg & ~nmi_sync_reg & nmi_func_sel;

    // ------------------------------------------------------------
    // Per-line field extraction
    // ------------------------------------------------------------
    logic [LEVEL_W-1:0] line_level [NUM_LINES];

    // Bits outside the four fields of a register are never read
    // Each line owns two bits of one register
    always_comb
    begin
        for (int i = 0; i < NUM_LINES; i++)
        begin
            line_level[i] = prio_regs[
                32*int'(prio_reg_of(LINE_W'(i)))
                + int'(field_pos_of(LINE_W'(i))) +: LEVEL_W];
        end
    end

    // ------------------------------------------------------------
    // Pending state
    // ------------------------------------------------------------
    logic [NUM_LINES-1:0] pend_reg;
    logic [NUM_LINES-1:0] pend_next;
    logic [NUM_LINES-1:0] clr_mask;
    logic [3:0] sys_pend_reg;
    logic [3:0] sys_pend_next;
    logic [3:0] sys_clr;
    ivpm_state_e state_reg;
    ivpm_state_e state_next;
    ivpm_vec_s sel_reg;
    ivpm_vec_s sel_next;

    // Disabled lines are refused here, so they never reach pending.
    // A level-held source re-pends after its ack, since set beats clear.
    wire [NUM_LINES-1:0] line_active = line_req & line_enable;
    wire [3:0] sys_req = {system_tick_req, pendable_service_req,
        supervisor_call_req, hard_fault_req};
    wire ack_now = (state_reg == IVPM_FETCH) & core_ack;

    // Clear the acknowledged entry; a new request in that cycle wins
    always_comb
    begin
        clr_mask = '0;
        sys_clr = '0;
        if (ack_now && sel_reg.vector >= VEC_LINE_BASE)
        begin
            clr_mask[LINE_W'(sel_reg.vector - VEC_LINE_BASE)] = 1'b1;
        end
        if (ack_now && sel_reg.vector == VEC_HARD_FAULT)
        begin
            sys_clr[0] = 1'b1;
        end
        if (ack_now && sel_reg.vector == VEC_SUPERVISOR_CALL)
        begin
            sys_clr[1] = 1'b1;
        end
        if (ack_now && sel_reg.vector == VEC_PENDABLE_SERVICE)
        begin
            sys_clr[2] = 1'b1;
        end
        if (ack_now && sel_reg.vector == VEC_SYSTEM_TICK)
        begin
            sys_clr[3] = 1'b1;
        end
        pend_next = (pend_reg & ~clr_mask) | line_active;
        sys_pend_next = (sys_pend_reg & ~sys_clr) | sys_req;
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    // Non-maskable first, then hard fault, then the system handlers,
    // then lines by level (0 highest) with the lower line on a tie.
    // The scan runs downward so an equal level found later, at a lower
    // line, replaces the earlier pick.
    logic nmi_clr;
    logic [LINE_W-1:0] best_line;
    logic [LEVEL_W-1:0] best_level;
    logic best_found;
    ivpm_vec_s cand;

    always_comb
    begin
        best_line = '0;
        best_level = '1;
        best_found = 1'b0;
        for (int i = NUM_LINES - 1; i >= 0; i--)
        begin
            if (pend_reg[i] && (!best_found || line_level[i] <= best_level))
            begin
                best_line = LINE_W'(i);
                best_level = line_level[i];
                best_found = 1'b1;
            end
        end
        cand = '0;
        if (nmi_pend_reg)
        begin
            cand.vector = VEC_NMI;
        end
        else if (sys_pend_reg[0])
        begin
            cand.vector = VEC_HARD_FAULT;
        end
        else if (sys_pend_reg[1])
        begin
            cand.vector = VEC_SUPERVISOR_CALL;
        end
        else if (sys_pend_reg[2])
        begin
            cand.vector = VEC_PENDABLE_SERVICE;
        end
        else if (sys_pend_reg[3])
        begin
            cand.vector = VEC_SYSTEM_TICK;
        end
        else
        begin
            cand.vector = VEC_LINE_BASE + VEC_W'(best_line);
            cand.level = best_level;
        end
        cand.valid = nmi_pend_reg | (|sys_pend_reg) | best_found;
        cand.addr = vec_addr_of(cand.vector);
    end

    // ------------------------------------------------------------
    // Hand-off sequencer
    // ------------------------------------------------------------
    // The choice is frozen in TAKE so the vector cannot move under
    // the core while it stacks it.
    // Limitation: a more urgent request arriving in TAKE or FETCH waits
    // until the offered vector has been acknowledged.
    always_comb
    begin
        state_next = state_reg;
        sel_next = sel_reg;
        nmi_clr = 1'b0;
        case (state_reg)
            IVPM_IDLE:
            begin
                if (cand.valid)
                begin
                    sel_next = cand;
                    state_next = IVPM_TAKE;
                end
            end
            IVPM_TAKE:
            begin
                state_next = IVPM_FETCH;
            end
            IVPM_FETCH:
            begin
                if (core_ack)
                begin
                    nmi_clr = (sel_reg.vector == VEC_NMI);
                    sel_next.valid = 1'b0;
                    state_next = IVPM_IDLE;
                end
            end
            default:
            begin
                state_next = IVPM_IDLE;
                sel_next = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= IVPM_IDLE;
            sel_reg <= '0;
            pend_reg <= PEND_RESET;
            sys_pend_reg <= 4'h0;
            nmi_pend_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            pend_reg <= pend_next;
            sys_pend_reg <= sys_pend_next;
            nmi_pend_reg <= (nmi_pend_reg & ~nmi_clr) | nmi_edge;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // core_req decodes the state alone, so it cannot glitch on core_ack;
    // the core may acknowledge in the first cycle it sees the request.
    // Core stacks vec_out.vector as the exception number
    assign vec_out = sel_reg;
    assign core_req = (state_reg == IVPM_FETCH);
    assign pending = pend_reg;

endmodule : ivpm_top

// *** testbench.sv ***
// Testbench for the interrupt vector and priority map.
// Assumes the core model acks each vector; inputs move 1 ns after edges.
`timescale 1ns/100ps

module testbench;
    import ivpm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ivpm_src_s src = '0;
    logic nmi_pin_n = 1'b1;
    logic nmi_func_sel = 1'b0;
    logic [NUM_PRIO_REGS*32-1:0] prio_regs = '0;
    logic [NUM_LINES-1:0] line_enable = '1;
    logic [3:0] sys_req = 4'h0;
    logic [3:0] ack_delay = 4'h0;
    logic core_ack;
    logic core_req;
    ivpm_vec_s vec_out;
    logic [NUM_LINES-1:0] pending;
    logic [NUM_LINES-1:0] line_req;
    int n_errors = 0;
    int num_checks = 0;
    // Line fed by each source bit, struct bit 0 first
    int line_of [36] = '{29, 29, 28, 27, 25, 24, 23, 22, 21, 20,
        19, 19, 19, 19, 19, 19, 19, 19, 17, 17, 17, 17, 17, 17, 17, 17,
        16, 15, 12, 10, 10, 8, 8, 7, 6, 5};

    ivpm_top i_ivpm_top (.clk, .rst, .src, .nmi_pin_n, .nmi_func_sel,
        .prio_regs, .line_enable, .hard_fault_req(sys_req[3]),
        .supervisor_call_req(sys_req[2]), .pendable_service_req(sys_req[1]),
        .system_tick_req(sys_req[0]), .core_ack, .core_req, .vec_out,
        .pending, .line_req);
    ivpm_core_model i_ivpm_core_model (.clk, .rst, .core_req,
        .delay(ack_delay), .core_ack);

    // Free-running core clock
    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Wait for an offered vector, judge it, then wait for the ack
    task automatic t_take(input logic [5:0] v, input logic [1:0] l);
        int k;
        k = 0;
        while (core_req !== 1'b1 && k < 40)
        begin
            cyc(1);
            k++;
        end
        chk(core_req, 1'b1);
        chk(vec_out.valid, 1'b1);
        chk(vec_out.vector, v);
        chk(vec_out.addr, {24'h0, v, 2'b00});
        chk(vec_out.level, l);
        src = '0;
        k = 0;
        while (core_req !== 1'b0 && k < 40)
        begin
            cyc(1);
            k++;
        end
        chk(core_req, 1'b0);
        cyc(1);
    endtask : t_take

    task automatic test_done();
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_route();
        line_enable = '0;
        for (int b = 0; b < 36; b++)
        begin
            src = ivpm_src_s'(36'h1 << b);
            cyc(1);
            chk(line_req, 32'h1 << line_of[b]);
        end
        src = '0;
        cyc(3);
        chk(pending, 32'h0);
        line_enable = '1;
    endtask : t_route

    task automatic t_deliver();
        int ln [7] = '{15, 16, 21, 10, 29, 5, 17};
        int bt [7] = '{27, 26, 8, 30, 0, 35, 25};
        logic [1:0] lv [7] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
        for (int i = 0; i < 7; i++)
        begin
            prio_regs[32*(ln[i]/4) + 8*(ln[i]%4) + 6 +: 2] = lv[i];
            src = ivpm_src_s'(36'h1 << bt[i]);
            t_take(6'(16 + ln[i]), lv[i]);
        end
    endtask : t_deliver

    // Two lines at once, slow core: lower level value goes first
    task automatic t_order();
        ack_delay = 4'h5;
        prio_regs[32*3 + 6 +: 2] = 2'h1;
        prio_regs[32*6 + 6 +: 2] = 2'h3;
        src.async_serial = 1'b1;
        src.keypad0 = 1'b1;
        t_take(6'h1C, 2'h1);
        t_take(6'h28, 2'h3);
        ack_delay = 4'h0;
    endtask : t_order

    task automatic t_system();
        logic [5:0] v [4] = '{6'h0F, 6'h0E, 6'h0B, 6'h03};
        for (int i = 0; i < 4; i++)
        begin
            sys_req = 4'h1 << i;
            cyc(1);
            sys_req = 4'h0;
            t_take(v[i], 2'h0);
        end
    endtask : t_system

    task automatic t_nmi();
        logic seen;
        seen = 1'b0;
        nmi_pin_n = 1'b0;
        // Watch every cycle: a fast core would hide a brief request
        repeat (10)
        begin
            cyc(1);
            seen = seen | core_req;
        end
        chk(seen, 1'b0);
        nmi_pin_n = 1'b1;
        cyc(4);
        nmi_func_sel = 1'b1;
        nmi_pin_n = 1'b0;
        t_take(6'h02, 2'h0);
        nmi_pin_n = 1'b1;
    endtask : t_nmi

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(core_req, 1'b0);
        chk(pending, 32'h0);
        t_route();
        t_deliver();
        t_order();
        t_system();
        t_nmi();
        test_done();
    end

    // Watchdog at 5000 cycles, far beyond the fewer than two hundred cycles the tests need
    initial
    begin
        #50000;
        n_errors++;
        test_done();
    end
endmodule : testbench
